// ---- include/pdag_pkg.sv ----
// package: paged data address generator constants
`default_nettype none
package pdag_pkg;
    // register byte offsets
    localparam logic [7:0] ADDR_READ_PAGE = 8'h00;
    localparam logic [7:0] ADDR_WRITE_PAGE = 8'h04;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h08;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
    localparam logic [7:0] ADDR_LAST_ADDR = 8'h10;
    // reset values
    localparam logic [9:0] RST_READ_PAGE = 10'h001;
    localparam logic [8:0] RST_WRITE_PAGE = 9'h001;
    localparam logic [2:0] RST_IRQ_MASK = 3'h0;
    // status bit positions
    localparam int BIT_RD_TRAP = 0;
    localparam int BIT_WR_TRAP = 1;
    localparam int BIT_PAGE_STEP = 2;
    // page boundary codes
    localparam logic [9:0] PG_ZERO = 10'h000;
    localparam logic [9:0] PG_FIRST = 10'h001;
    localparam logic [9:0] PG_EDS_LAST = 10'h1FF;
    localparam logic [9:0] PG_PSV_FIRST_LSW = 10'h200;
    localparam logic [9:0] PG_PSV_LAST_LSW = 10'h2FF;
    localparam logic [9:0] PG_PSV_FIRST_MSB = 10'h300;
    localparam logic [9:0] PG_PSV_LAST_MSB = 10'h3FF;
    // addressing modes
    typedef enum logic [2:0] {
        PDAG_MODE_DIRECT,
        PDAG_MODE_PRE_POST,
        PDAG_MODE_REG_OFFSET,
        PDAG_MODE_MODULO,
        PDAG_MODE_BIT_REV
    } pdag_mode_e;
    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// ---- hdl/pdag_top.sv ----
// paged data address generator with axi4-lite page registers
`default_nettype none
module pdag_top (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // axi4-lite write address
    input wire logic [7:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    // axi4-lite read address
    input wire logic [7:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    // read access from the address generator
    input wire logic rd_valid_in,
    input wire logic [15:0] rd_ea_in,
    input wire logic [15:0] rd_ea_calc_in,
    input wire logic rd_carry_in,
    input wire logic rd_borrow_in,
    input wire pdag_pkg::pdag_mode_e rd_mode_in,
    // write access from the address generator
    input wire logic wr_valid_in,
    input wire logic [15:0] wr_ea_in,
    input wire logic [15:0] wr_ea_calc_in,
    input wire logic wr_carry_in,
    input wire logic wr_borrow_in,
    input wire pdag_pkg::pdag_mode_e wr_mode_in,
    // memory side
    output logic rd_addr_valid_out,
    output logic [23:0] rd_addr_out,
    output logic rd_paged_out,
    output logic [15:0] rd_ea_next_out,
    output logic wr_addr_valid_out,
    output logic [23:0] wr_addr_out,
    output logic wr_paged_out,
    output logic [15:0] wr_ea_next_out,
    output logic addr_trap_out,
    // interrupt
    output logic irq_out
);
    import pdag_pkg::*;

    typedef struct packed {
        logic [9:0] page;
        logic bit15;
    } pdag_step_s;

    // page step for one access; calc bit 15 is already cleared by carry
    function automatic pdag_step_s step_page(input logic [9:0] pg, input logic is_rd, input logic carry,
                                             input logic borrow, input pdag_mode_e mode, input logic ea15);
        pdag_step_s r;
        r.page = pg;
        r.bit15 = 1'b1;
        if (!ea15 || mode == PDAG_MODE_DIRECT || !(carry || borrow))
        begin
            r.bit15 = 1'b0;
        end
        else if (mode != PDAG_MODE_PRE_POST)
        begin
            r.bit15 = 1'b1;
        end
        else if (carry)
        begin
            if (pg == PG_EDS_LAST || (is_rd && pg == PG_PSV_LAST_MSB))
                r.bit15 = 1'b0;
            else if (is_rd && pg == PG_PSV_LAST_LSW)
                r.page = PG_PSV_FIRST_MSB;
            else
                r.page = 10'(pg + 10'h001);
        end
        else
        begin
            if (is_rd && (pg == PG_FIRST || pg == PG_PSV_FIRST_LSW))
                r.bit15 = 1'b0;
            else if (is_rd && pg == PG_PSV_FIRST_MSB)
                r.page = PG_PSV_LAST_LSW;
            else if (!is_rd && pg == PG_FIRST)
                r.bit15 = 1'b0;
            else
                r.page = 10'(pg - 10'h001);
        end
        return r;
    endfunction

    // page registers
    logic [9:0] read_page_ff;
    logic [8:0] write_page_ff;
    logic [2:0] irq_status_ff;
    logic [2:0] irq_mask_ff;

    // access path
    logic rd_go, wr_go, rd_trap, wr_trap;
    pdag_step_s rd_step, wr_step;
    logic [15:0] rd_ea_fix, wr_ea_fix;
    assign rd_go = rd_valid_in && rd_ea_in[15];
    assign wr_go = wr_valid_in && wr_ea_in[15];
    assign rd_trap = rd_go && read_page_ff == PG_ZERO;
    assign wr_trap = wr_go && write_page_ff == PG_ZERO[8:0];
    // detection needs bit 15 of the unmodified address
    assign rd_step = step_page(read_page_ff, 1'b1, rd_carry_in, rd_borrow_in, rd_mode_in, rd_ea_in[15]);
    assign wr_step = step_page({1'b0, write_page_ff}, 1'b0, wr_carry_in, wr_borrow_in, wr_mode_in, wr_ea_in[15]);
    // bit 15 of the raw calculation is replaced on a paged carry or borrow outside direct mode
    assign rd_ea_fix = (rd_go && (rd_carry_in || rd_borrow_in) && rd_mode_in != PDAG_MODE_DIRECT)
        ? {rd_step.bit15, rd_ea_calc_in[14:0]} : rd_ea_calc_in;
    assign wr_ea_fix = (wr_go && (wr_carry_in || wr_borrow_in) && wr_mode_in != PDAG_MODE_DIRECT)
        ? {wr_step.bit15, wr_ea_calc_in[14:0]} : wr_ea_calc_in;

    // bus slave
    logic aw_hold_ff, w_hold_ff;
    logic [7:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic bus_wr, bus_rd;
    logic [31:0] rd_mux;
    logic rd_hit;
    logic [23:0] last_addr_ff;
    assign bus_wr = aw_hold_ff && w_hold_ff && !s_axi_bvalid_out;
    assign bus_rd = s_axi_arvalid_in && s_axi_arready_out;
    assign rd_hit = s_axi_araddr_in == ADDR_READ_PAGE || s_axi_araddr_in == ADDR_WRITE_PAGE
        || s_axi_araddr_in == ADDR_IRQ_STATUS || s_axi_araddr_in == ADDR_IRQ_MASK
        || s_axi_araddr_in == ADDR_LAST_ADDR;
    assign rd_mux = (s_axi_araddr_in == ADDR_READ_PAGE) ? {22'h0, read_page_ff}
        : (s_axi_araddr_in == ADDR_WRITE_PAGE) ? {23'h0, write_page_ff}
        : (s_axi_araddr_in == ADDR_IRQ_STATUS) ? {29'h0, irq_status_ff}
        : (s_axi_araddr_in == ADDR_IRQ_MASK) ? {29'h0, irq_mask_ff}
        : (s_axi_araddr_in == ADDR_LAST_ADDR) ? {8'h0, last_addr_ff} : 32'h0;

    logic wr_is_rp, wr_is_wp, wr_is_st, wr_is_mk, wr_hit;
    assign wr_is_rp = bus_wr && awaddr_ff == ADDR_READ_PAGE;
    assign wr_is_wp = bus_wr && awaddr_ff == ADDR_WRITE_PAGE;
    assign wr_is_st = bus_wr && awaddr_ff == ADDR_IRQ_STATUS;
    assign wr_is_mk = bus_wr && awaddr_ff == ADDR_IRQ_MASK;
    assign wr_hit = wr_is_rp || wr_is_wp || wr_is_st || wr_is_mk || awaddr_ff == ADDR_LAST_ADDR;

    // next page values: hardware stepping has priority over software writes
    logic [9:0] nxt_read_page;
    logic [8:0] nxt_write_page;
    logic [2:0] nxt_irq_status;
    logic [2:0] set_bits;
    assign nxt_read_page = (rd_go && !rd_trap) ? rd_step.page
        : wr_is_rp ? {wstrb_ff[1] ? wdata_ff[9:8] : read_page_ff[9:8],
                      wstrb_ff[0] ? wdata_ff[7:0] : read_page_ff[7:0]} : read_page_ff;
    assign nxt_write_page = (wr_go && !wr_trap && !write_page_ff[8]) ? wr_step.page[8:0]
        : wr_is_wp ? {wstrb_ff[1] ? wdata_ff[8] : write_page_ff[8],
                      wstrb_ff[0] ? wdata_ff[7:0] : write_page_ff[7:0]} : write_page_ff;
    assign set_bits = {(rd_go && rd_step.page != read_page_ff) || (wr_go && wr_step.page[8:0] != write_page_ff),
                       wr_trap || (wr_go && write_page_ff[8]), rd_trap};
    // set wins over write-one-to-clear
    assign nxt_irq_status = (irq_status_ff & ~((wr_is_st && wstrb_ff[0]) ? wdata_ff[2:0] : 3'h0)) | set_bits;

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            read_page_ff <= RST_READ_PAGE;
            write_page_ff <= RST_WRITE_PAGE;
            irq_status_ff <= 3'h0;
            irq_mask_ff <= RST_IRQ_MASK;
            irq_out <= 1'b0;
        end
        else
        begin
            read_page_ff <= nxt_read_page;
            write_page_ff <= nxt_write_page;
            irq_status_ff <= nxt_irq_status;
            if (wr_is_mk && wstrb_ff[0])
                irq_mask_ff <= wdata_ff[2:0];
            irq_out <= |(nxt_irq_status & irq_mask_ff);
        end
    end

    // address outputs, registered
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            rd_addr_valid_out <= 1'b0;
            rd_addr_out <= 24'h0;
            rd_paged_out <= 1'b0;
            rd_ea_next_out <= 16'h0;
            wr_addr_valid_out <= 1'b0;
            wr_addr_out <= 24'h0;
            wr_paged_out <= 1'b0;
            wr_ea_next_out <= 16'h0;
            addr_trap_out <= 1'b0;
            last_addr_ff <= 24'h0;
        end
        else
        begin
            rd_addr_valid_out <= rd_valid_in && !rd_trap;
            // page bits 8:0 over ea bits 14:0; base space otherwise
            rd_addr_out <= rd_ea_in[15] ? {read_page_ff[8:0], rd_ea_in[14:0]}
                : {8'h0, rd_ea_in};
            rd_paged_out <= rd_ea_in[15] && rd_valid_in;
            rd_ea_next_out <= rd_ea_fix;
            wr_addr_valid_out <= wr_valid_in && !wr_trap && !(wr_go && write_page_ff[8]);
            wr_addr_out <= wr_ea_in[15] ? {write_page_ff, wr_ea_in[14:0]} : {8'h0, wr_ea_in};
            wr_paged_out <= wr_ea_in[15] && wr_valid_in;
            wr_ea_next_out <= wr_ea_fix;
            addr_trap_out <= rd_trap || wr_trap || (wr_go && write_page_ff[8]);
            if (rd_go)
                last_addr_ff <= {read_page_ff[8:0], rd_ea_in[14:0]};
        end
    end

    // axi4-lite handshakes
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            aw_hold_ff <= 1'b0;
            w_hold_ff <= 1'b0;
            awaddr_ff <= 8'h0;
            wdata_ff <= 32'h0;
            wstrb_ff <= 4'h0;
            s_axi_awready_out <= 1'b1;
            s_axi_wready_out <= 1'b1;
            s_axi_bvalid_out <= 1'b0;
            s_axi_bresp_out <= RESP_OKAY;
            s_axi_arready_out <= 1'b1;
            s_axi_rvalid_out <= 1'b0;
            s_axi_rdata_out <= 32'h0;
            s_axi_rresp_out <= RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid_in && s_axi_awready_out)
            begin
                aw_hold_ff <= 1'b1;
                awaddr_ff <= s_axi_awaddr_in;
                s_axi_awready_out <= 1'b0;
            end
            if (s_axi_wvalid_in && s_axi_wready_out)
            begin
                w_hold_ff <= 1'b1;
                wdata_ff <= s_axi_wdata_in;
                wstrb_ff <= s_axi_wstrb_in;
                s_axi_wready_out <= 1'b0;
            end
            if (bus_wr)
            begin
                s_axi_bvalid_out <= 1'b1;
                s_axi_bresp_out <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_axi_bvalid_out && s_axi_bready_in)
            begin
                s_axi_bvalid_out <= 1'b0;
                aw_hold_ff <= 1'b0;
                w_hold_ff <= 1'b0;
                s_axi_awready_out <= 1'b1;
                s_axi_wready_out <= 1'b1;
            end
            if (bus_rd)
            begin
                s_axi_arready_out <= 1'b0;
                s_axi_rvalid_out <= 1'b1;
                s_axi_rdata_out <= rd_mux;
                s_axi_rresp_out <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_axi_rvalid_out && s_axi_rready_in)
            begin
                s_axi_rvalid_out <= 1'b0;
                s_axi_arready_out <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ---- sim/pdag_checker.sv ----
// concurrent checks on the paged address generator ports
`default_nettype none
module pdag_checker (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // access inputs
    input wire logic rd_valid_in,
    input wire logic [15:0] rd_ea_in,
    input wire logic [15:0] rd_ea_calc_in,
    input wire logic rd_carry_in,
    input wire logic rd_borrow_in,
    input wire pdag_pkg::pdag_mode_e rd_mode_in,
    input wire logic wr_valid_in,
    input wire logic [15:0] wr_ea_in,
    input wire logic [15:0] wr_ea_calc_in,
    // memory side
    input wire logic rd_addr_valid_out,
    input wire logic [23:0] rd_addr_out,
    input wire logic [15:0] rd_ea_next_out,
    input wire logic [23:0] wr_addr_out,
    input wire logic [15:0] wr_ea_next_out,
    input wire logic addr_trap_out
);
    timeunit 1ns;
    timeprecision 1ps;
    import pdag_pkg::*;
    default clocking @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);
    AST_RD_BASE_ADDR: assert property (
        rd_valid_in && !rd_ea_in[15] && rd_ea_in == rd_ea_calc_in
        |=> rd_addr_valid_out && rd_addr_out == {8'h00, $past(rd_ea_in)}) else $error("base read address wrong");
    AST_WR_BASE_ADDR: assert property (
        wr_valid_in && !wr_ea_in[15] && wr_ea_in == wr_ea_calc_in
        |=> wr_addr_out == {8'h00, $past(wr_ea_in)}) else $error("base write address wrong");
    AST_RD_BASE_NEXT: assert property (
        rd_valid_in && !rd_ea_in[15] |=> rd_ea_next_out == $past(rd_ea_calc_in)) else $error("base read ea changed");
    AST_WR_BASE_NEXT: assert property (
        wr_valid_in && !wr_ea_in[15] |=> wr_ea_next_out == $past(wr_ea_calc_in)) else $error("base write ea changed");
    AST_RD_WRAP: assert property (
        rd_valid_in && rd_ea_in[15] && (rd_carry_in || rd_borrow_in) && rd_mode_in inside
        {PDAG_MODE_REG_OFFSET, PDAG_MODE_MODULO, PDAG_MODE_BIT_REV}
        |=> rd_ea_next_out == {1'b1, $past(rd_ea_calc_in[14:0])}) else $error("wrap ea wrong");
    AST_RD_STEP_LOW: assert property (
        rd_valid_in && rd_ea_in[15] && rd_carry_in && rd_mode_in == PDAG_MODE_PRE_POST
        |=> rd_ea_next_out[14:0] == $past(rd_ea_calc_in[14:0])) else $error("stepped ea low bits wrong");
    AST_NO_BASE_TRAP: assert property (
        rd_valid_in && wr_valid_in && !rd_ea_in[15] && !wr_ea_in[15] |=> !addr_trap_out) else $error("base trap");
    AST_RD_IDLE: assert property (
        !rd_valid_in |=> !rd_addr_valid_out) else $error("read address without access");
    cover property (rd_valid_in && rd_borrow_in);
    cover property (addr_trap_out);
    cover property (rd_valid_in && wr_valid_in);
endmodule
bind pdag_top pdag_checker u_pdag_checker (.clk_in, .rst_n_in, .rd_valid_in, .rd_ea_in, .rd_ea_calc_in,
    .rd_carry_in, .rd_borrow_in, .rd_mode_in, .wr_valid_in, .wr_ea_in, .wr_ea_calc_in, .rd_addr_valid_out,
    .rd_addr_out, .rd_ea_next_out, .wr_addr_out, .wr_ea_next_out, .addr_trap_out);
`default_nettype wire

// ---- sim/pdag_agu_model.sv ----
// address generator model driving one access path
`default_nettype none
module pdag_agu_model (
    // request from the bench
    input wire logic go_in,
    input wire logic [15:0] ea_in,
    input wire logic [15:0] st_in,
    input wire pdag_pkg::pdag_mode_e md_in,
    // access towards the block
    output logic v_out,
    output logic [15:0] ea_out,
    output logic [15:0] c_out,
    output logic cy_out,
    output logic bw_out,
    output var pdag_pkg::pdag_mode_e md_out
);
    timeunit 1ns;
    timeprecision 1ps;
    assign v_out = go_in;
    // idle path shows a scrambled address
    assign ea_out = go_in ? ea_in : ~ea_in;
    assign c_out = go_in ? ea_in + st_in : ~(ea_in + st_in);
    // leaving the upper half marks a carry or borrow
    assign cy_out = go_in && ea_in[15] && !c_out[15] && !st_in[15];
    assign bw_out = go_in && ea_in[15] && !c_out[15] && st_in[15];
    assign md_out = md_in;
endmodule
`default_nettype wire

// ---- sim/testbench.sv ----
// self-checking bench for the paged address generator
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import pdag_pkg::*;
    logic clk_in, rst_n_in, rgo, wgo;
    logic [7:0] s_axi_awaddr_in, s_axi_araddr_in;
    logic [31:0] s_axi_wdata_in, s_axi_rdata_out, d;
    logic [3:0] s_axi_wstrb_in;
    logic [1:0] s_axi_bresp_out, s_axi_rresp_out, rs;
    logic s_axi_awvalid_in, s_axi_awready_out, s_axi_wvalid_in, s_axi_wready_out, s_axi_bvalid_out;
    logic s_axi_bready_in, s_axi_arvalid_in, s_axi_arready_out, s_axi_rvalid_out, s_axi_rready_in;
    logic rd_valid_in, rd_carry_in, rd_borrow_in, wr_valid_in, wr_carry_in, wr_borrow_in;
    logic [15:0] rd_ea_in, rd_ea_calc_in, wr_ea_in, wr_ea_calc_in, rd_ea_next_out, wr_ea_next_out, ea, e;
    logic signed [15:0] st;
    pdag_mode_e rd_mode_in, wr_mode_in, md;
    logic rd_addr_valid_out, rd_paged_out, wr_addr_valid_out, wr_paged_out, addr_trap_out, irq_out;
    logic [23:0] rd_addr_out, wr_addr_out;
    int fail_count, n_compared, pg, wp, x, r;
    int pgs[16] = '{'h1FF, 'h2FF, 'h3FF, 'h005, 'h001, 'h200, 'h300, 'h005, 'h005, 'h005, 'h005, 'h005,
        'h1FF, 'h001, 'h010, 'h010};
    int mds[16] = '{1, 1, 1, 1, 1, 1, 1, 1, 2, 3, 4, 0, 1, 1, 1, 3};
    bit dn[16] = '{0, 0, 0, 0, 1, 1, 1, 1, 0, 0, 1, 0, 0, 1, 0, 1};
    pdag_top u_dut (.clk_in, .rst_n_in, .s_axi_awaddr_in, .s_axi_awvalid_in, .s_axi_awready_out,
        .s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bresp_out,
        .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_araddr_in, .s_axi_arvalid_in, .s_axi_arready_out,
        .s_axi_rdata_out, .s_axi_rresp_out, .s_axi_rvalid_out, .s_axi_rready_in, .rd_valid_in, .rd_ea_in,
        .rd_ea_calc_in, .rd_carry_in, .rd_borrow_in, .rd_mode_in, .wr_valid_in, .wr_ea_in, .wr_ea_calc_in,
        .wr_carry_in, .wr_borrow_in, .wr_mode_in, .rd_addr_valid_out, .rd_addr_out, .rd_paged_out,
        .rd_ea_next_out, .wr_addr_valid_out, .wr_addr_out, .wr_paged_out, .wr_ea_next_out, .addr_trap_out,
        .irq_out);
    pdag_agu_model u_rd (.go_in(rgo), .ea_in(ea), .st_in(st), .md_in(md), .v_out(rd_valid_in),
        .ea_out(rd_ea_in), .c_out(rd_ea_calc_in), .cy_out(rd_carry_in), .bw_out(rd_borrow_in), .md_out(rd_mode_in));
    pdag_agu_model u_wr (.go_in(wgo), .ea_in(ea), .st_in(st), .md_in(md), .v_out(wr_valid_in),
        .ea_out(wr_ea_in), .c_out(wr_ea_calc_in), .cy_out(wr_carry_in), .bw_out(wr_borrow_in), .md_out(wr_mode_in));
    initial
    begin
        clk_in = 1'b0;
        forever #2 clk_in = ~clk_in;
    end
    initial
    begin
        repeat (20000) @(posedge clk_in);
        fail_count++;
        test_done();
    end
    task automatic test_done();
        if (fail_count == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] %0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_in);
        s_axi_awaddr_in <= a;
        s_axi_wdata_in <= v;
        s_axi_awvalid_in <= 1'b1;
        s_axi_wvalid_in <= 1'b1;
        s_axi_bready_in <= 1'b1;
        do
        begin
            @(posedge clk_in);
            if (s_axi_awready_out)
                s_axi_awvalid_in <= 1'b0;
            if (s_axi_wready_out)
                s_axi_wvalid_in <= 1'b0;
        end
        while (!s_axi_bvalid_out);
        rs = s_axi_bresp_out;
        s_axi_bready_in <= 1'b0;
    endtask
    task automatic axi_rd(input logic [7:0] a);
        @(posedge clk_in);
        s_axi_araddr_in <= a;
        s_axi_arvalid_in <= 1'b1;
        s_axi_rready_in <= 1'b1;
        do
        begin
            @(posedge clk_in);
            if (s_axi_arready_out)
                s_axi_arvalid_in <= 1'b0;
        end
        while (!s_axi_rvalid_out);
        d = s_axi_rdata_out;
        rs = s_axi_rresp_out;
        s_axi_rready_in <= 1'b0;
    endtask
    // one access cycle, outputs sampled after the taking edge
    task automatic acc(input logic a, input logic b);
        @(posedge clk_in);
        rgo <= a;
        wgo <= b;
        @(posedge clk_in);
        rgo <= 1'b0;
        wgo <= 1'b0;
        #1;
    endtask
    // reference: next ea and page after one paged access
    function automatic int nxt_ea(input int a, input int s, input int m, inout int p);
        int c;
        c = (a + s) & 'hFFFF;
        if (!a[15] || c[15] || m == 0)
            return c;
        if (m != 1)
            return c | 'h8000;
        if (s > 0 ? (p == 'h1FF || p == 'h3FF) : (p == 1 || p == 'h200))
            return c;
        p = s > 0 ? p + 1 : p - 1;
        return c | 'h8000;
    endfunction
    initial
    begin
        rst_n_in = 1'b0;
        {rgo, wgo, s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, s_axi_arvalid_in, s_axi_rready_in} = '0;
        {s_axi_awaddr_in, s_axi_araddr_in, s_axi_wdata_in, ea, st} = '0;
        s_axi_wstrb_in = 4'hF;
        md = PDAG_MODE_DIRECT;
        fail_count = 0;
        n_compared = 0;
        r = $urandom(32'hA86AE509);
        repeat (6) @(posedge clk_in);
        rst_n_in <= 1'b1;
        axi_rd(ADDR_READ_PAGE);
        chk(d, 1);
        axi_rd(ADDR_WRITE_PAGE);
        chk(d, 1);
        axi_rd(ADDR_IRQ_MASK);
        chk(d, 0);
        axi_rd(8'h14);
        chk(d, 0);
        chk(rs, RESP_SLVERR);
        axi_wr(8'h14, 32'h0000005A);
        chk(rs, RESP_SLVERR);
        axi_wr(ADDR_READ_PAGE, 32'hFFFFFFFF);
        chk(rs, RESP_OKAY);
        axi_rd(ADDR_READ_PAGE);
        chk(d, 'h3FF);
        for (int i = 0; i < 16; i++)
        begin
            x = 2 * ($urandom % 8);
            pg = pgs[i];
            axi_wr(i > 11 ? ADDR_WRITE_PAGE : ADDR_READ_PAGE, pg);
            e = 16'(dn[i] ? 'h8000 + x : 'hFFFE - x);
            r = dn[i] ? -(x + 2) : x + 4;
            ea <= e;
            st <= 16'(r);
            md <= pdag_mode_e'(mds[i]);
            x = nxt_ea(e, r, mds[i], pg);
            acc(i < 12, i > 11);
            if (mds[i] != 0)
                chk(i > 11 ? wr_ea_next_out : rd_ea_next_out, x);
            axi_rd(i > 11 ? ADDR_WRITE_PAGE : ADDR_READ_PAGE);
            chk(d, pg);
        end
        axi_rd(ADDR_IRQ_STATUS);
        chk(d & 4, 4);
        pg = 1 + $urandom % 'h1FE;
        wp = 1 + $urandom % 'hFF;
        e = 16'h8000 | 16'($urandom);
        axi_wr(ADDR_READ_PAGE, pg);
        axi_wr(ADDR_WRITE_PAGE, wp);
        ea <= e;
        st <= '0;
        md <= PDAG_MODE_PRE_POST;
        acc(1'b1, 1'b1);
        chk(rd_addr_out, pg << 15 | e[14:0]);
        chk(wr_addr_out, wp << 15 | e[14:0]);
        chk(rd_paged_out, 1);
        chk(wr_paged_out, 1);
        chk(rd_addr_valid_out, 1);
        chk(wr_addr_valid_out, 1);
        axi_rd(ADDR_LAST_ADDR);
        chk(d, pg << 15 | e[14:0]);
        e = 16'($urandom) & 16'h7FFF;
        ea <= e;
        acc(1'b1, 1'b1);
        chk(rd_addr_out, e);
        chk(wr_addr_out, e);
        chk(rd_paged_out, 0);
        chk(wr_paged_out, 0);
        axi_wr(ADDR_IRQ_STATUS, 7);
        axi_wr(ADDR_IRQ_MASK, 1);
        axi_wr(ADDR_READ_PAGE, 0);
        ea <= 16'h8100;
        acc(1'b1, 1'b0);
        chk(addr_trap_out, 1);
        chk(rd_addr_valid_out, 0);
        chk(irq_out, 1);
        axi_rd(ADDR_IRQ_STATUS);
        chk(d, 1);
        axi_wr(ADDR_IRQ_STATUS, 1);
        chk(irq_out, 0);
        axi_wr(ADDR_IRQ_MASK, 0);
        acc(1'b1, 1'b0);
        chk(irq_out, 0);
        axi_wr(ADDR_WRITE_PAGE, 0);
        acc(1'b0, 1'b1);
        chk(addr_trap_out, 1);
        chk(wr_addr_valid_out, 0);
        test_done();
    end
endmodule
`default_nettype wire
